// [common/ddcm_pkg.sv]
// package: register map, field layout, reset values and tables of the ddc
package ddcm_pkg;
  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_PIN_FUNC_LO = 16'h0041;
  localparam logic [15:0] ADDR_PIN_FUNC_HI = 16'h0042;
  localparam logic [15:0] ADDR_CHIP_CFG = 16'h0200;
  localparam logic [15:0] ADDR_SYNC_CTL = 16'h0300;
  localparam logic [15:0] ADDR_STATUS = 16'h0301;
  localparam logic [15:0] ADDR_DDC_CTL [4] = '{16'h0310, 16'h0330,
                                              16'h0350, 16'h0370};
  localparam logic [7:0] RST_REG = 8'h00;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int PIN_TRIG_IN_BIT = 0;   // pin func lo: trigger input assigned
  localparam int PIN_MASTER_BIT = 1;    // pin func lo: device is master
  localparam int PIN_USE_IN_BIT = 0;    // pin func hi: master arms from input
  localparam int CTL_COMPLEX_BIT = 7;
  localparam int CTL_REAL_OUT_BIT = 6;
  localparam int CTL_FILT_LSB = 0;
  localparam int CTL_FILT_W = 4;
  localparam int SYNC_EN_LSB = 0;       // two bits, nonzero enables sync
  localparam int SYNC_TRIG_BIT = 1;     // sysref gated by the arm
  localparam int SYNC_ARM_BIT = 2;      // write 1: arm (master, own source)
  localparam int SYNC_SOFT_RST_BIT = 4;
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_OVERRUN_BIT = 1;
  localparam int STAT_BADCFG_BIT = 2;

  // ----------------------------------------------------------------------
  // datapath tables
  // ----------------------------------------------------------------------
  localparam int NUM_COMBOS = 14;
  localparam logic [5:0] CPLX_RATIO [14] = '{6'h02, 6'h03, 6'h04, 6'h06,
    6'h08, 6'h0a, 6'h0c, 6'h0f, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h28, 6'h30};
  localparam logic [13:0] WIDE_THIRD_MASK = 14'h0882; // combos 1, 7, 11
  localparam logic signed [15:0] CPLX_GAIN = 16'sh5a04; // -3.06 db, q15
  localparam logic [15:0] QSIN [8] = '{16'h0c8c, 16'h2528, 16'h3c57,
    16'h5133, 16'h62f2, 16'h70e2, 16'h7a7c, 16'h7f61};
endpackage : ddcm_pkg

// [design/ddcm_buf.sv]
// two-entry valid/ready buffer in the output data path
module ddcm_buf #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic wp_ff;
  logic rp_ff;
  logic [1:0] cnt_ff;
  logic push;
  logic pop;

  if (W < 1) begin : g_bad_w
    $error("ddcm_buf: width must be positive");
  end

  // full only at two words, so a stalled reader never drops data
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rp_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wp_ff <= wp_ff ^ push;
      rp_ff <= rp_ff ^ pop;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // ddcm_buf

// [design/ddcm_mixer.sv]
// quadrature mixer with bypass, real and complex modes
module ddcm_mixer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode
  input wire logic bypass,
  input wire logic complex_in,
  // samples and local oscillator
  input wire logic signed [W-1:0] in_i,
  input wire logic signed [W-1:0] in_q,
  input wire logic signed [W-1:0] lo_cos,
  input wire logic signed [W-1:0] lo_sin,
  // mixed samples
  output logic signed [W-1:0] out_i,
  output logic signed [W-1:0] out_q
);
  localparam int PW = 2 * W;
  localparam int SW = PW + 17;
  logic signed [PW-1:0] p_ic, p_qs, p_qc, p_is;
  logic signed [PW:0] sum_i, sum_q;
  logic signed [SW-1:0] sc_i, sc_q;
  logic signed [PW-1:0] neg_is;

  assign p_ic = in_i * lo_cos;
  assign p_qs = in_q * lo_sin;
  assign p_qc = in_q * lo_cos;
  assign p_is = in_i * lo_sin;
  assign neg_is = -p_is;
  // full complex product (i + jq)(cos - j sin): two adders
  assign sum_i = {p_ic[PW-1], p_ic} + {p_qs[PW-1], p_qs};
  assign sum_q = {p_qc[PW-1], p_qc} - {p_is[PW-1], p_is};
  localparam logic signed [15:0] CPLX_GAIN_EXT = ddcm_pkg::CPLX_GAIN;

  // scale down so 1.414x full scale peaks stay in range
  assign sc_i = sum_i * CPLX_GAIN_EXT;
  assign sc_q = sum_q * CPLX_GAIN_EXT;

  // output register: bypass, real or complex
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_i <= '0;
      out_q <= '0;
    end else if (bypass) begin
      out_i <= in_i;
      out_q <= in_q;
    end else if (complex_in) begin
      out_i <= sc_i[PW+13 -: W];
      out_q <= sc_q[PW+13 -: W];
    end else begin
      out_i <= p_ic[PW-2 -: W];
      out_q <= neg_is[PW-2 -: W];
    end
  end

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
      bypass |=> (out_i == $past(in_i)) && (out_q == $past(in_q));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("mixer bypass did not pass samples through");
endmodule // ddcm_mixer

// [design/ddcm_top.sv]
// one downconverter channel: trigger sync, oscillator, mixer, decimator
// Behaviour
// - in triggered mode sysref syncs only while the arm is set
// - slave arms from the trigger input pin
// - master drives trigger out, optionally uses input
// - startup sysref aligns oscillators and frame counters
// - armed resync realigns after new tuning words
// - mixer bypassed when chip config is zero
// - real input: two multipliers, cos and sin
// - complex input: four multipliers, two adders
// - control bit 7 picks real or complex
// - complex mixing scaled down by 3.06 db
// - oscillator spurs below 102 dbc; the five-bit phase table here falls far short
// - cascaded decimating low-pass stages after mixer; a single boxcar stands in for them here
// - wide third-band only in channels 0, 1
// - filters keep 80 percent band alias free
// - fourteen complex ratios, real ratios half
// - deepest chain gives 24 real, 48 complex
// - enabled sysref resets every phase accumulator, in triggered mode only while armed
// - soft reset high then low clears accumulators
module ddcm_top #(
  parameter int SAMPLE_W = 16,
  parameter int PHASE_W = 48,
  parameter int DDC_INDEX = 0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // sync pins
  input wire logic sysref_pin,
  input wire logic slave_trigger_in_pin,
  output logic master_trigger_out_pin,
  // tuning and converter samples
  input wire logic [PHASE_W-1:0] tuning_word,
  input wire logic signed [SAMPLE_W-1:0] adc_i,
  input wire logic signed [SAMPLE_W-1:0] adc_q,
  // decimated output stream
  output logic out_valid,
  input wire logic out_ready,
  output logic signed [SAMPLE_W-1:0] out_i,
  output logic signed [SAMPLE_W-1:0] out_q
);
  localparam int ACC_W = SAMPLE_W + 6;

  if (SAMPLE_W != 16 || PHASE_W < 5 || DDC_INDEX < 0 || DDC_INDEX > 3)
  begin : g_bad_cfg
    $error("ddcm_top: unsupported sample width, phase width or index");
  end

  // --------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------
  // index of the control register hit, 4 when none
  function automatic logic [2:0] ctl_hit(input logic [15:0] a);
    ctl_hit = 3'h4;
    for (int k = 0; k < 4; k++) begin
      if (a == ddcm_pkg::ADDR_DDC_CTL[k]) begin
        ctl_hit = 3'(k);
      end
    end
  endfunction

  // quarter-wave sine from the top five phase bits
  function automatic logic signed [15:0] qsin(input logic [4:0] ph);
    logic [2:0] idx;
    logic [15:0] mag;
    idx = ph[3] ? ~ph[2:0] : ph[2:0];
    mag = ddcm_pkg::QSIN[idx];
    qsin = ph[4] ? -$signed(mag) : $signed(mag);
  endfunction

  // shift that keeps a sum of n samples inside the output width
  function automatic logic [2:0] clog2n(input logic [5:0] n);
    clog2n = 3'h0;
    for (int k = 0; k < 6; k++) begin
      if ((7'h01 << k) < {1'b0, n}) begin
        clog2n = 3'(k + 1);
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0] pin_lo_ff, pin_hi_ff, chip_cfg_ff, sync_ctl_ff;
  logic [7:0] ddc_ctl_ff [4];
  logic overrun_ff, arm_ff, bad_cfg;
  logic [2:0] hit;
  logic arm_req;

  assign hit = ctl_hit(reg_addr);
  assign arm_req = reg_wr_en && (reg_addr == ddcm_pkg::ADDR_SYNC_CTL) &&
                   reg_wdata[ddcm_pkg::SYNC_ARM_BIT];

  // software writes; the arm bit is a self-clearing request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_lo_ff <= ddcm_pkg::RST_REG;
      pin_hi_ff <= ddcm_pkg::RST_REG;
      chip_cfg_ff <= ddcm_pkg::RST_REG;
      sync_ctl_ff <= ddcm_pkg::RST_REG;
      for (int k = 0; k < 4; k++) begin
        ddc_ctl_ff[k] <= ddcm_pkg::RST_REG;
      end
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        ddcm_pkg::ADDR_PIN_FUNC_LO: pin_lo_ff <= reg_wdata;
        ddcm_pkg::ADDR_PIN_FUNC_HI: pin_hi_ff <= reg_wdata;
        ddcm_pkg::ADDR_CHIP_CFG: chip_cfg_ff <= reg_wdata;
        ddcm_pkg::ADDR_SYNC_CTL: begin
          sync_ctl_ff <= reg_wdata & ~(8'h01 << ddcm_pkg::SYNC_ARM_BIT);
        end
        default: begin
          if (!hit[2]) begin
            ddc_ctl_ff[hit[1:0]] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      unique case (reg_addr)
        ddcm_pkg::ADDR_PIN_FUNC_LO: reg_rdata <= pin_lo_ff;
        ddcm_pkg::ADDR_PIN_FUNC_HI: reg_rdata <= pin_hi_ff;
        ddcm_pkg::ADDR_CHIP_CFG: reg_rdata <= chip_cfg_ff;
        ddcm_pkg::ADDR_SYNC_CTL: reg_rdata <= sync_ctl_ff;
        ddcm_pkg::ADDR_STATUS: begin
          reg_rdata <= {5'h00, bad_cfg, overrun_ff, arm_ff};
        end
        default: reg_rdata <= hit[2] ? 8'h00 : ddc_ctl_ff[hit[1:0]];
      endcase
    end
  end

  // --------------------------------------------------------------------
  // trigger and sysref synchronisation
  // --------------------------------------------------------------------
  logic sref_s1_ff, sref_s2_ff, sref_s3_ff;
  logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic is_master, use_pin, sync_on, trig_mode, soft_rst;
  logic sref_rise, trig_rise, sync_evt, arm_set;

  // pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {sref_s1_ff, sref_s2_ff, sref_s3_ff} <= 3'h0;
      {trig_s1_ff, trig_s2_ff, trig_s3_ff} <= 3'h0;
    end else begin
      {sref_s1_ff, sref_s2_ff, sref_s3_ff} <=
        {sysref_pin, sref_s1_ff, sref_s2_ff};
      {trig_s1_ff, trig_s2_ff, trig_s3_ff} <=
        {slave_trigger_in_pin, trig_s1_ff, trig_s2_ff};
    end
  end

  assign is_master = pin_lo_ff[ddcm_pkg::PIN_MASTER_BIT];
  assign use_pin = !is_master || pin_hi_ff[ddcm_pkg::PIN_USE_IN_BIT];
  assign sync_on = (sync_ctl_ff[ddcm_pkg::SYNC_EN_LSB +: 2] != 2'h0);
  assign trig_mode = sync_ctl_ff[ddcm_pkg::SYNC_TRIG_BIT];
  assign soft_rst = sync_ctl_ff[ddcm_pkg::SYNC_SOFT_RST_BIT];
  assign sref_rise = sref_s2_ff && !sref_s3_ff;
  // the input only counts once it is routed to the trigger function
  assign trig_rise = trig_s2_ff && !trig_s3_ff &&
                     pin_lo_ff[ddcm_pkg::PIN_TRIG_IN_BIT];
  assign arm_set = use_pin ? trig_rise : arm_req;
  // in triggered mode a sysref edge only counts while armed
  assign sync_evt = sref_rise && sync_on &&
                    (!trig_mode || arm_ff);

  // arm: a new arm in the consuming cycle wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_ff <= 1'b0;
    end else if (arm_set) begin
      arm_ff <= 1'b1;
    end else if (sync_evt && trig_mode) begin
      arm_ff <= 1'b0;
    end
  end

  // trigger out is registered so every slave sees it on the same edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_trigger_out_pin <= 1'b0;
    end else begin
      master_trigger_out_pin <= is_master && !use_pin && arm_ff;
    end
  end

  // --------------------------------------------------------------------
  // oscillator and mixer
  // --------------------------------------------------------------------
  logic [PHASE_W-1:0] phase_accumulator_ff;
  logic [4:0] ph_top;
  logic signed [SAMPLE_W-1:0] lo_cos_ff, lo_sin_ff, adc_i_ff, adc_q_ff;
  logic signed [SAMPLE_W-1:0] mix_i, mix_q;
  logic [7:0] ctl;

  assign ph_top = phase_accumulator_ff[PHASE_W-1 -: 5];
  assign ctl = ddc_ctl_ff[DDC_INDEX];

  // one sync event aligns every channel and chip at once; the soft reset
  // holds it at zero while high, so only in-chip alignment is possible
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_accumulator_ff <= '0;
    end else if (sync_evt || soft_rst) begin
      phase_accumulator_ff <= '0;
    end else begin
      phase_accumulator_ff <= phase_accumulator_ff + tuning_word;
    end
  end

  // small table: spur level is set by table depth, a known limitation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cos_ff <= '0;
      lo_sin_ff <= '0;
      adc_i_ff <= '0;
      adc_q_ff <= '0;
    end else begin
      lo_cos_ff <= qsin(ph_top + 5'h08);
      lo_sin_ff <= qsin(ph_top);
      adc_i_ff <= adc_i;
      adc_q_ff <= adc_q;
    end
  end

  ddcm_mixer #(.W(SAMPLE_W)) u_mixer (
    .clk(core_clk),
    .rst_n(rst_n),
    .bypass(chip_cfg_ff == 8'h00),
    .complex_in(ctl[ddcm_pkg::CTL_COMPLEX_BIT]),
    .in_i(adc_i_ff),
    .in_q(adc_q_ff),
    .lo_cos(lo_cos_ff),
    .lo_sin(lo_sin_ff),
    .out_i(mix_i),
    .out_q(mix_q)
  );

  // --------------------------------------------------------------------
  // decimation
  // --------------------------------------------------------------------
  logic [3:0] combo;
  logic real_out, wide_combo, dump, buf_ready;
  logic [5:0] ratio, cnt_ff;
  logic [2:0] shift;
  logic signed [ACC_W-1:0] acc_i_ff, acc_q_ff, sum_i, sum_q;
  logic signed [SAMPLE_W-1:0] pend_i_ff, pend_q_ff;
  logic pend_ff;

  assign combo = ctl[ddcm_pkg::CTL_FILT_LSB +: ddcm_pkg::CTL_FILT_W];
  assign real_out = ctl[ddcm_pkg::CTL_REAL_OUT_BIT];
  assign wide_combo = (combo < 4'(ddcm_pkg::NUM_COMBOS)) &&
                      ddcm_pkg::WIDE_THIRD_MASK[combo];
  // wide third-band is complex-only and absent past channel 1
  assign bad_cfg = (combo >= 4'(ddcm_pkg::NUM_COMBOS)) ||
                   (wide_combo && (real_out || DDC_INDEX > 1));
  // real output runs at half the complex ratio
  assign ratio = bad_cfg ? 6'h01 :
                 (real_out ? {1'b0, ddcm_pkg::CPLX_RATIO[combo][5:1]}
                           : ddcm_pkg::CPLX_RATIO[combo]);
  assign shift = clog2n(ratio);
  assign dump = !bad_cfg && (cnt_ff == ratio - 6'h01);
  assign sum_i = acc_i_ff + ACC_W'(mix_i);
  assign sum_q = acc_q_ff + ACC_W'(mix_q);

  // boxcar decimator stands in for the filter cascade; sync restarts it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 6'h00;
      acc_i_ff <= '0;
      acc_q_ff <= '0;
    end else if (sync_evt || soft_rst || bad_cfg || dump) begin
      cnt_ff <= 6'h00;
      acc_i_ff <= '0;
      acc_q_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
      acc_i_ff <= sum_i;
      acc_q_ff <= sum_q;
    end
  end

  // a word waits here while the buffer is full; a new dump overwrites it and it is lost
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
      pend_i_ff <= '0;
      pend_q_ff <= '0;
    end else if (dump) begin
      pend_ff <= 1'b1;
      pend_i_ff <= SAMPLE_W'(sum_i >>> shift);
      pend_q_ff <= real_out ? '0 : SAMPLE_W'(sum_q >>> shift);
    end else if (buf_ready) begin
      pend_ff <= 1'b0;
    end
  end

  // overrun is sticky; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_ff <= 1'b0;
    end else if (dump && pend_ff && !buf_ready) begin
      overrun_ff <= 1'b1;
    end else if (reg_wr_en && reg_addr == ddcm_pkg::ADDR_STATUS &&
                 reg_wdata[ddcm_pkg::STAT_OVERRUN_BIT]) begin
      overrun_ff <= 1'b0;
    end
  end

  ddcm_buf #(.W(2 * SAMPLE_W)) u_buf (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(pend_ff),
    .in_ready(buf_ready),
    .in_data({pend_i_ff, pend_q_ff}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_i, out_q})
  );

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_arm_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (sref_rise && sync_on && trig_mode && !arm_ff) |=> 
        (phase_accumulator_ff != '0) || $past(soft_rst) ||
        ($past(phase_accumulator_ff) + $past(tuning_word) == '0);
  endproperty
  a_arm_gate: assert property (p_arm_gate)
    else $error("unarmed sysref reset the phase accumulator");

  property p_slave_arm;
    @(posedge core_clk) disable iff (!rst_n)
      (!is_master && pin_lo_ff[ddcm_pkg::PIN_TRIG_IN_BIT] &&
       $rose(trig_s2_ff) && !reg_wr_en) |=> arm_ff;
  endproperty
  a_slave_arm: assert property (p_slave_arm)
    else $error("slave did not arm on trigger input edge");

  property p_master_out;
    @(posedge core_clk) disable iff (!rst_n)
      (arm_req && is_master && !use_pin && !reg_rd_en) ##1
        (is_master && !use_pin) |=> master_trigger_out_pin;
  endproperty
  a_master_out: assert property (p_master_out)
    else $error("master did not drive trigger out two cycles after arm");

  property p_sync_zero;
    @(posedge core_clk) disable iff (!rst_n)
      sync_evt |=> (phase_accumulator_ff == '0) && (cnt_ff == 6'h00);
  endproperty
  a_sync_zero: assert property (p_sync_zero)
    else $error("sync event did not clear accumulator and decimator");

  property p_soft_rst;
    @(posedge core_clk) disable iff (!rst_n)
      soft_rst ##1 soft_rst |-> phase_accumulator_ff == '0;
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("phase accumulator not held by soft reset");

  property p_arm_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (sync_evt && trig_mode && !arm_set) |=> !arm_ff;
  endproperty
  a_arm_clear: assert property (p_arm_clear)
    else $error("arm not cleared after consumed sysref");

  property p_wide_third;
    @(posedge core_clk) disable iff (!rst_n)
      dump |-> !(wide_combo && (DDC_INDEX > 1 || real_out));
  endproperty
  a_wide_third: assert property (p_wide_third)
    else $error("wide third-band combination used where unsupported");

  property p_ratio;
    @(posedge core_clk) disable iff (!rst_n)
      (dump && !real_out && combo == 4'hd) |-> cnt_ff == 6'h2f;
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("deepest chain did not decimate by 48");

  c_sync: cover property (@(posedge core_clk) disable iff (!rst_n)
    sync_evt && trig_mode);
  c_dump: cover property (@(posedge core_clk) disable iff (!rst_n)
    out_valid && out_ready);
  c_overrun: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(overrun_ff));
endmodule // ddcm_top

// [sim/ddcm_peer.sv]
// peer converter model: drives the shared sysref and trigger lines
module ddcm_peer (
  // clock
  input wire logic core_clk,
  // shared sync lines, idle low
  output logic sysref_pin,
  output logic trig_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sysref_pin = 1'b0;
    trig_pin = 1'b0;
  end
  // pulse held four edges so the two-flop synchroniser cannot miss it
  task automatic pulse(input bit sref);
    @(posedge core_clk);
    if (sref) begin
      sysref_pin <= 1'b1;
    end else begin
      trig_pin <= 1'b1;
    end
    repeat (4) @(posedge core_clk);
    sysref_pin <= 1'b0;
    trig_pin <= 1'b0;
  endtask
endmodule // ddcm_peer

// [sim/ddcm_top_test.sv]
// testbench of one downconverter channel
module ddcm_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, reg_wr_en, reg_rd_en, sysref_pin;
  logic slave_trigger_in_pin, master_trigger_out_pin, out_valid, out_ready;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, hi_rdata;
  logic [47:0] tuning_word;
  logic signed [15:0] adc_i, adc_q, out_i, out_q;
  int mismatches, n_compared, cyc, t0;
  int combo [3] = '{0, 4, 13};
  int ratio [3] = '{2, 8, 48};
  ddcm_top u_dut (.core_clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .sysref_pin, .slave_trigger_in_pin,
    .master_trigger_out_pin, .tuning_word, .adc_i, .adc_q, .out_valid,
    .out_ready, .out_i, .out_q);
  ddcm_peer u_peer (.core_clk, .sysref_pin,
    .trig_pin(slave_trigger_in_pin));
  // a channel past the second one, where the wide third band is absent
  ddcm_top #(.DDC_INDEX(2)) u_dut_hi (.core_clk, .rst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata(hi_rdata), .sysref_pin,
    .slave_trigger_in_pin, .master_trigger_out_pin(), .tuning_word,
    .adc_i, .adc_q, .out_valid(), .out_ready, .out_i(), .out_q());
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // cycle count, also cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
  endtask
  // data registered at the taking edge, sampled one edge later
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    #1 check({8'h00, reg_rdata}, {8'h00, e}, "read");
  endtask
  // looks once the buffer has settled; the word leaves at the next edge
  task automatic take();
    do begin
      @(posedge core_clk);
      #1;
    end while (!(out_valid === 1'b1 && out_ready));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  localparam logic [15:0] SYNC = ddcm_pkg::ADDR_SYNC_CTL;
  localparam logic [15:0] STAT = ddcm_pkg::ADDR_STATUS;
  localparam logic [15:0] PINL = ddcm_pkg::ADDR_PIN_FUNC_LO;
  localparam logic [15:0] CTL0 = ddcm_pkg::ADDR_DDC_CTL[0];
  initial begin
    {rst_n, reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
    {tuning_word, adc_q, mismatches, n_compared} = '0;
    adc_i = 16'sh0100;
    adc_q = 16'sh0040;
    out_ready = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, unmapped place, control readback
    rd_reg(ddcm_pkg::ADDR_CHIP_CFG, ddcm_pkg::RST_REG);
    rd_reg(CTL0, ddcm_pkg::RST_REG);
    rd_reg(16'h0123, 8'h00);
    wr_reg(CTL0, 8'h8d);
    rd_reg(CTL0, 8'h8d);
    wr_reg(CTL0, 8'h00);
    $display("test regs done");
    // bypassed mixer: constant input survives a ratio-2 boxcar
    repeat (4) take();
    check(out_i, 16'h0100, "bypass");
    check(out_q, 16'h0040, "bypass q");
    $display("test bypass done");
    // mixer on, oscillator parked at phase zero by a zero tuning word
    wr_reg(ddcm_pkg::ADDR_CHIP_CFG, 8'h01);
    wr_reg(CTL0, 8'h40);
    repeat (4) take();
    // real mix with no gain stage: cosine peak entry times 0x100
    check(out_i, 16'h00fe, "real mix");
    check(out_q, 16'h0000, "real q");
    wr_reg(CTL0, 8'h80);
    repeat (4) take();
    // complex product of (0x100, 0x40) with the same entries, less 3.06 db
    check(out_i, 16'h00b7, "cplx mix i");
    check(out_q, 16'h001b, "cplx mix q");
    tuning_word <= 48'h0123_4567_89ab;
    $display("test mixer done");
    // word spacing equals the complex ratio, deepest chain last
    foreach (combo[k]) begin
      wr_reg(CTL0, 8'h80 | 8'(combo[k]));
      repeat (2) take();
      t0 = cyc;
      take();
      check(16'(cyc - t0), 16'(ratio[k]), "spacing");
    end
    $display("test ratios done");
    // wide third band refused in real out, index 14 refused
    wr_reg(CTL0, 8'h41);
    rd_reg(STAT, 8'h04);
    wr_reg(CTL0, 8'h0e);
    rd_reg(STAT, 8'h04);
    wr_reg(CTL0, 8'h00);
    rd_reg(STAT, 8'h00);
    // only the own control register steers a channel
    wr_reg(ddcm_pkg::ADDR_DDC_CTL[2], 8'h81);
    rd_reg(STAT, 8'h00);
    check({8'h00, hi_rdata}, 16'h0004, "wide hi");
    $display("test badcfg done");
    // receiver stalls: buffer holds, then overrun flagged and cleared
    out_ready <= 1'b0;
    settle(30);
    check({15'h0, out_valid}, 16'h1, "stall hold");
    rd_reg(STAT, 8'h02);
    out_ready <= 1'b1;
    wr_reg(STAT, 8'h02);
    rd_reg(STAT, 8'h00);
    $display("test stall done");
    // soft reset holds the decimator too, so the stream stops while high
    wr_reg(SYNC, 8'h10);
    settle(8);
    check({15'h0, out_valid}, 16'h0, "soft rst");
    wr_reg(SYNC, 8'h00);
    take();
    $display("test soft reset done");
    // master arms itself, drives the trigger, sysref consumes the arm
    wr_reg(PINL, 8'h02);
    wr_reg(SYNC, 8'h06);
    settle(3);
    check({15'h0, master_trigger_out_pin}, 16'h1, "mto");
    rd_reg(STAT, 8'h01);
    u_peer.pulse(1'b1);
    settle(6);
    check({15'h0, master_trigger_out_pin}, 16'h0, "mto");
    rd_reg(STAT, 8'h00);
    u_peer.pulse(1'b1);
    settle(6);
    rd_reg(STAT, 8'h00);
    $display("test master done");
    // slave ignores trigger until the pin is assigned
    wr_reg(PINL, 8'h00);
    wr_reg(SYNC, 8'h02);
    u_peer.pulse(1'b0);
    settle(6);
    rd_reg(STAT, 8'h00);
    wr_reg(PINL, 8'h01);
    u_peer.pulse(1'b0);
    settle(6);
    rd_reg(STAT, 8'h01);
    u_peer.pulse(1'b1);
    settle(6);
    rd_reg(STAT, 8'h00);
    $display("test slave done");
    // master set to arm from the input pin ignores its own arm request
    wr_reg(PINL, 8'h03);
    wr_reg(ddcm_pkg::ADDR_PIN_FUNC_HI, 8'h01);
    wr_reg(SYNC, 8'h06);
    settle(3);
    rd_reg(STAT, 8'h00);
    u_peer.pulse(1'b0);
    settle(6);
    rd_reg(STAT, 8'h01);
    check({15'h0, master_trigger_out_pin}, 16'h0, "mto idle");
    u_peer.pulse(1'b1);
    settle(6);
    rd_reg(STAT, 8'h00);
    $display("test master input done");
    stop_test();
  end
endmodule // ddcm_top_test
